// File: fewr_host.sv
// Purpose: serial host model
// Assumes: mode 0, 400 ns serial clock
// Notes: si shows the inverse of its last bit when deselected
`timescale 1ns/10ps
module fewr_host (
	output logic cs_n,
	output logic sclk,
	output logic si,
	input logic so,
	input logic so_oe
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end
	// sends the low n bits of d, msb first
	task automatic frame(input logic [39:0] d, input int n);
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			si = d[i];
			#200 sclk = 1'b1;
			#200 sclk = 1'b0;
		end
		#100 cs_n = 1'b1;
		si = ~si;
		#400;
	endtask
	// reads one status byte after code 05h, sampled on the rising serial clock
	task automatic status(output logic [7:0] s, output logic oe);
		logic [15:0] w;
		w = 16'h0500;
		s = 8'h00;
		oe = 1'b0;
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			si = w[i];
			#200 sclk = 1'b1;
			if (i < 8) begin
				s[i] = so;
				oe = so_oe;
			end
			#200 sclk = 1'b0;
		end
		#100 cs_n = 1'b1;
		si = ~si;
		#400;
	endtask
endmodule // fewr_host

// File: fewr_properties.sv
// Purpose: port checker of the erase sequencer
// Assumes: one clock domain
// Notes: bound to every sequencer instance
`timescale 1ns/10ps
module fewr_properties (
	input wire clock,
	input wire rst,
	input wire [4:0] block_protect_bits,
	input wire region_protected,
	input wire erase_start,
	input wire [2:0] erase_kind,
	input wire write_enable_latch,
	input wire write_in_progress,
	input wire [2:0] wrap_setting_bits,
	input wire quad_read_load,
	input wire quad_read_byte_done,
	input wire [23:0] quad_read_addr
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_one_pulse: assert property (erase_start |=> !erase_start)
		else $error("start pulse too long");
	a_needs_wel: assert property (erase_start |-> $past(write_enable_latch))
		else $error("start without latch");
	a_busy_start: assert property (erase_start |-> !$past(write_in_progress))
		else $error("start while busy");
	a_start_sets: assert property (erase_start |-> write_in_progress && !write_enable_latch)
		else $error("start flags wrong");
	a_wip_cause: assert property ($rose(write_in_progress) |-> erase_start)
		else $error("busy without start");
	a_chip_free: assert property (erase_start && erase_kind == 3'h5 |->
		$past(block_protect_bits) == 5'h00) else $error("chip clear protected");
	a_region_free: assert property (erase_start && erase_kind != 3'h5 |->
		!$past(region_protected)) else $error("region clear protected");
	a_addr_step: assert property (quad_read_byte_done && !quad_read_load && wrap_setting_bits[0]
		|=> quad_read_addr == $past(quad_read_addr) + 24'h1) else $error("bad step");
	c_chip: cover property (erase_start && erase_kind == 3'h5);
	c_done: cover property ($fell(write_in_progress));
	c_wrap: cover property (quad_read_byte_done && !wrap_setting_bits[0]);
endmodule // fewr_properties
////////////////////////////////////////////////////////////////
bind fewr_sequencer fewr_properties props (.*);

// File: fewr_regs.vh
// Purpose: constants for the erase and burst-wrap command sequencer
// Assumes: 20 MHz system clock, mode 0 serial link sampled by that clock
// Notes: timing figures are defaults, the top module exposes them as parameters
`ifndef FEWR_REGS_VH
`define FEWR_REGS_VH

`define FEWR_CMD_WREN 8'h06
`define FEWR_CMD_RDSR 8'h05
`define FEWR_CMD_WRAP 8'h77
`define FEWR_CMD_PAGE 8'h81
`define FEWR_CMD_SECT 8'h20
`define FEWR_CMD_HALF 8'h52
`define FEWR_CMD_BLK 8'hD8
`define FEWR_CMD_CHIP1 8'h60
`define FEWR_CMD_CHIP2 8'hC7

`define FEWR_BITS_CMD 6'h08
`define FEWR_BITS_ADDR 6'h20
`define FEWR_BITS_WRAP 6'h28
`define FEWR_BITS_MAX 6'h3F

`define FEWR_KIND_NONE 3'h0
`define FEWR_KIND_PAGE 3'h1
`define FEWR_KIND_SECT 3'h2
`define FEWR_KIND_HALF 3'h3
`define FEWR_KIND_BLK 3'h4
`define FEWR_KIND_CHIP 3'h5

`define FEWR_WRAP_RESET 3'h7
`define FEWR_WRAP_OFF_BIT 0
`define FEWR_WRAP_LSB 4

`define FEWR_CLOCK_MHZ 20
`define FEWR_PAGE_CLEAR_TIME_US 1000
`define FEWR_SMALL_UNIT_CLEAR_TIME_US 2000
`define FEWR_HALF_BLOCK_CLEAR_TIME_US 4000
`define FEWR_BLOCK_CLEAR_TIME_US 8000
`define FEWR_WHOLE_ARRAY_CLEAR_TIME_US 16000

`endif

// File: fewr_sequencer.v
// Purpose: erase command and burst-wrap handling of a serial flash
// Assumes: link pins come from outside the clock domain, protection lookup is external
// Notes: the array itself is outside, driven by erase_start with kind and address
`timescale 1ns/10ps
`include "fewr_regs.vh"

module fewr_sequencer #(
	parameter PAGE_CLEAR_TIME_US = `FEWR_PAGE_CLEAR_TIME_US,
	parameter SMALL_UNIT_CLEAR_TIME_US = `FEWR_SMALL_UNIT_CLEAR_TIME_US,
	parameter HALF_BLOCK_CLEAR_TIME_US = `FEWR_HALF_BLOCK_CLEAR_TIME_US,
	parameter BLOCK_CLEAR_TIME_US = `FEWR_BLOCK_CLEAR_TIME_US,
	parameter WHOLE_ARRAY_CLEAR_TIME_US = `FEWR_WHOLE_ARRAY_CLEAR_TIME_US
) (
	input wire clock,
	input wire rst,
	input wire cs_n,
	input wire sclk,
	input wire si,
	output reg so,
	output reg so_oe,
	input wire [4:0] block_protect_bits,
	input wire region_protected,
	output wire [23:0] check_addr,
	output wire [2:0] check_kind,
	output reg erase_start,
	output reg [2:0] erase_kind,
	output reg [23:0] erase_addr,
	output reg write_enable_latch,
	output reg write_in_progress,
	output reg [2:0] wrap_setting_bits,
	input wire quad_read_load,
	input wire [23:0] quad_read_start_addr,
	input wire quad_read_byte_done,
	output reg [23:0] quad_read_addr
);

localparam [31:0] PAGE_CYC = PAGE_CLEAR_TIME_US * `FEWR_CLOCK_MHZ;
localparam [31:0] SECT_CYC = SMALL_UNIT_CLEAR_TIME_US * `FEWR_CLOCK_MHZ;
localparam [31:0] HALF_CYC = HALF_BLOCK_CLEAR_TIME_US * `FEWR_CLOCK_MHZ;
localparam [31:0] BLK_CYC = BLOCK_CLEAR_TIME_US * `FEWR_CLOCK_MHZ;
localparam [31:0] CHIP_CYC = WHOLE_ARRAY_CLEAR_TIME_US * `FEWR_CLOCK_MHZ;

////////////////////////////////////////////////////////////////////////////////
// decoding shared by several places

function [2:0] kind_of;
	input [7:0] code;
	begin
		case (code)
			`FEWR_CMD_PAGE: kind_of = `FEWR_KIND_PAGE;
			`FEWR_CMD_SECT: kind_of = `FEWR_KIND_SECT;
			`FEWR_CMD_HALF: kind_of = `FEWR_KIND_HALF;
			`FEWR_CMD_BLK: kind_of = `FEWR_KIND_BLK;
			`FEWR_CMD_CHIP1: kind_of = `FEWR_KIND_CHIP;
			`FEWR_CMD_CHIP2: kind_of = `FEWR_KIND_CHIP;
			default: kind_of = `FEWR_KIND_NONE;
		endcase
	end
endfunction

function [31:0] cycles_of;
	input [2:0] kind;
	begin
		case (kind)
			`FEWR_KIND_PAGE: cycles_of = PAGE_CYC;
			`FEWR_KIND_SECT: cycles_of = SECT_CYC;
			`FEWR_KIND_HALF: cycles_of = HALF_CYC;
			`FEWR_KIND_BLK: cycles_of = BLK_CYC;
			default: cycles_of = CHIP_CYC;
		endcase
	end
endfunction

// next quad read address with optional section wrap
function [23:0] next_read;
	input [23:0] addr;
	input [2:0] wrap;
	reg [7:0] mask;
	reg [23:0] inc;
	begin
		mask = 8'h00;
		inc = addr + 24'h000001;
		case (wrap[2:1])
			2'b00: mask = 8'h07;
			2'b01: mask = 8'h0F;
			2'b10: mask = 8'h1F;
			default: mask = 8'h3F;
		endcase
		if (wrap[`FEWR_WRAP_OFF_BIT])
			next_read = inc;
		else
			next_read = {addr[23:8], (addr[7:0] & ~mask) | (inc[7:0] & mask)};
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// link synchronisers and edges

reg cs_s1, cs_s2, cs_s3;
reg sclk_s1, sclk_s2, sclk_s3;
reg si_s1, si_s2;

always @(posedge clock or posedge rst) begin
	if (rst) begin
		cs_s1 <= 1'b1;
		cs_s2 <= 1'b1;
		cs_s3 <= 1'b1;
		sclk_s1 <= 1'b0;
		sclk_s2 <= 1'b0;
		sclk_s3 <= 1'b0;
		si_s1 <= 1'b0;
		si_s2 <= 1'b0;
	end else begin
		cs_s1 <= cs_n;
		cs_s2 <= cs_s1;
		cs_s3 <= cs_s2;
		sclk_s1 <= sclk;
		sclk_s2 <= sclk_s1;
		sclk_s3 <= sclk_s2;
		si_s1 <= si;
		si_s2 <= si_s1;
	end
end

wire selected = ~cs_s2;
wire sclk_rise = selected & sclk_s2 & ~sclk_s3;
wire sclk_fall = selected & ~sclk_s2 & sclk_s3;
wire cs_rise = cs_s2 & ~cs_s3;

////////////////////////////////////////////////////////////////////////////////
// command shifter

reg [5:0] bit_count;
reg [7:0] command;
reg [31:0] shifter;
wire [7:0] code_now = {shifter[6:0], si_s2};

always @(posedge clock or posedge rst) begin
	if (rst) begin
		bit_count <= 6'h00;
		command <= 8'h00;
		shifter <= 32'h00000000;
	end else if (!selected) begin
		bit_count <= 6'h00;
	end else if (sclk_rise) begin
		shifter <= {shifter[30:0], si_s2};
		if (bit_count != `FEWR_BITS_MAX)
			bit_count <= bit_count + 6'h01;
		if (bit_count == `FEWR_BITS_CMD - 6'h01)
			command <= code_now;
	end
end

wire [2:0] cmd_kind = kind_of(command);
wire region_cmd = (cmd_kind != `FEWR_KIND_NONE) & (cmd_kind != `FEWR_KIND_CHIP);
wire chip_cmd = cmd_kind == `FEWR_KIND_CHIP;
wire region_len_ok = bit_count == `FEWR_BITS_ADDR;
wire chip_len_ok = bit_count == `FEWR_BITS_CMD;
wire wren_now = sclk_rise & (bit_count == `FEWR_BITS_CMD - 6'h01) & (code_now == `FEWR_CMD_WREN);

assign check_addr = shifter[23:0];
assign check_kind = cmd_kind;

wire region_go = region_cmd & region_len_ok & ~region_protected;
wire chip_go = chip_cmd & chip_len_ok & (block_protect_bits == 5'h00);
wire erase_go = cs_rise & ~write_in_progress & write_enable_latch & (region_go | chip_go);
wire wrap_go = cs_rise & ~write_in_progress & (command == `FEWR_CMD_WRAP) & (bit_count == `FEWR_BITS_WRAP);

////////////////////////////////////////////////////////////////////////////////
// latch, wrap setting and erase timer

reg [31:0] timer;

always @(posedge clock or posedge rst) begin
	if (rst) begin
		write_enable_latch <= 1'b0;
		write_in_progress <= 1'b0;
		wrap_setting_bits <= `FEWR_WRAP_RESET;
		timer <= 32'h00000000;
		erase_start <= 1'b0;
		erase_kind <= `FEWR_KIND_NONE;
		erase_addr <= 24'h000000;
	end else begin
		erase_start <= 1'b0;
		if (wren_now && !write_in_progress)
			write_enable_latch <= 1'b1;
		if (wrap_go)
			wrap_setting_bits <= shifter[`FEWR_WRAP_LSB+2:`FEWR_WRAP_LSB];
		if (erase_go) begin
			write_in_progress <= 1'b1;
			write_enable_latch <= 1'b0;
			timer <= cycles_of(cmd_kind) - 32'h00000001;
			erase_start <= 1'b1;
			erase_kind <= cmd_kind;
			erase_addr <= chip_cmd ? 24'h000000 : shifter[23:0];
		end else if (write_in_progress) begin
			if (timer == 32'h00000000)
				write_in_progress <= 1'b0;
			else
				timer <= timer - 32'h00000001;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// status read, answered also during an erase

wire [7:0] status = {1'b0, block_protect_bits, write_enable_latch, write_in_progress};
wire status_read = (command == `FEWR_CMD_RDSR) & (bit_count >= `FEWR_BITS_CMD);

// bit position inside the status byte, keeps counting past the saturated frame count
reg [2:0] read_phase;

always @(posedge clock or posedge rst) begin
	if (rst)
		read_phase <= 3'h0;
	else if (!selected)
		read_phase <= 3'h0;
	else if (sclk_rise)
		read_phase <= read_phase + 3'h1;
end

always @(posedge clock or posedge rst) begin
	if (rst) begin
		so <= 1'b0;
		so_oe <= 1'b0;
	end else if (!selected) begin
		so_oe <= 1'b0;
	end else if (sclk_fall && status_read) begin
		so_oe <= 1'b1;
		so <= status[3'h7 - read_phase];
	end
end

////////////////////////////////////////////////////////////////////////////////
// quad read address generator

always @(posedge clock or posedge rst) begin
	if (rst)
		quad_read_addr <= 24'h000000;
	else if (quad_read_load)
		quad_read_addr <= quad_read_start_addr;
	else if (quad_read_byte_done)
		quad_read_addr <= next_read(quad_read_addr, wrap_setting_bits);
end

endmodule // fewr_sequencer

// File: fewr_tb.sv
// Purpose: bench of the erase and burst-wrap sequencer
// Assumes: clears last 20 clocks, whole array 800
// Notes: protect lookup and quad strobes come from here
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
	$display("mismatch %0t %0h %0h", $time, a, e); end end
module testbench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [4:0] block_protect_bits = 5'h00;
	logic region_protected = 1'b0;
	logic quad_read_load = 1'b0;
	logic [23:0] quad_read_start_addr = 24'h000000;
	logic quad_read_byte_done = 1'b0;
	wire cs_n, sclk, si, so, so_oe, erase_start, write_enable_latch, write_in_progress;
	wire [23:0] check_addr, erase_addr, quad_read_addr;
	wire [2:0] check_kind, erase_kind, wrap_setting_bits;
	int fails = 0;
	int n_tests = 0;
	int n_starts = 0;
	logic [7:0] st;
	logic oe;
	logic [7:0] codes [6] = '{8'h81, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
	logic [2:0] kinds [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5};
	always #25 clock = ~clock;
	// counts start pulses away from the edge that launches them
	always @(negedge clock)
		if (erase_start === 1'b1)
			n_starts++;
	fewr_sequencer #(.PAGE_CLEAR_TIME_US(1), .SMALL_UNIT_CLEAR_TIME_US(1),
		.HALF_BLOCK_CLEAR_TIME_US(1), .BLOCK_CLEAR_TIME_US(1),
		.WHOLE_ARRAY_CLEAR_TIME_US(40)) dut (.*);
	fewr_host host (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));
	////////////////////////////////////////////////////////////////
	task automatic go(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wren();
		host.frame(40'h06, 8);
		`CHK(write_enable_latch, 1'b1)
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 1000 && write_in_progress; i++) go(1);
		`CHK(write_in_progress, 1'b0)
	endtask
	// k of zero expects a refusal
	task automatic clear(input logic [7:0] c, input int n, input logic [2:0] k);
		host.frame({c, 24'h0123C5} >> (32 - n), n);
		`CHK(write_in_progress, k != 3'h0)
		if (k != 3'h0) begin
			`CHK(erase_kind, k)
			`CHK(erase_addr, k == 3'h5 ? 24'h0 : 24'h0123C5)
			`CHK(write_enable_latch, 1'b0)
			`CHK(check_kind, k)
			if (k != 3'h5)
				`CHK(check_addr, 24'h0123C5)
		end
		wait_idle();
	endtask
	task automatic quad(input logic [23:0] a, input logic [23:0] e);
		quad_read_start_addr = a;
		quad_read_load = 1'b1;
		go(1);
		quad_read_load = 1'b0;
		quad_read_byte_done = 1'b1;
		go(1);
		quad_read_byte_done = 1'b0;
		`CHK(quad_read_addr, e)
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		go(6);
		rst = 1'b0;
		go(3);
		`CHK(wrap_setting_bits, 3'h7)
		clear(8'hD8, 32, 3'h0);
		for (int j = 0; j < 6; j++) begin
			wren();
			clear(codes[j], j < 4 ? 32 : 8, kinds[j]);
		end
		$display("test kinds done");
		wren();
		clear(8'h20, 31, 3'h0);
		clear(8'hC7, 16, 3'h0);
		region_protected = 1'b1;
		clear(8'h52, 32, 3'h0);
		region_protected = 1'b0;
		block_protect_bits = 5'h04;
		clear(8'h60, 8, 3'h0);
		host.status(st, oe);
		`CHK({oe, st}, 9'h112)
		`CHK(so_oe, 1'b0)
		block_protect_bits = 5'h00;
		`CHK(write_enable_latch, 1'b1)
		host.frame(40'h60, 8);
		host.status(st, oe);
		`CHK({oe, st}, 9'h101)
		host.frame(40'h06, 8);
		host.frame({8'h77, 24'h0, 8'h00}, 40);
		`CHK({write_enable_latch, wrap_setting_bits}, 4'h7)
		wait_idle();
		$display("test refusals done");
		for (int s = 0; s < 4; s++) begin
			host.frame({8'h77, 24'h0, 1'b0, s[1:0], 5'h00}, 40);
			`CHK(wrap_setting_bits, {s[1:0], 1'b0})
			quad(24'h0000FF + (24'h8 << s), 24'h000100);
		end
		host.frame({8'h77, 24'h0, 8'h70}, 40);
		`CHK(wrap_setting_bits, 3'h7)
		quad(24'hFFFFFF, 24'h000000);
		$display("test wrap done");
		host.frame({8'h77, 24'h0, 8'h00}, 40);
		wren();
		rst = 1'b1;
		go(2);
		`CHK({write_enable_latch, write_in_progress, wrap_setting_bits}, 5'h07)
		rst = 1'b0;
		go(3);
		wren();
		clear(8'h81, 32, 3'h1);
		`CHK(n_starts, 8)
		$display("test reset done");
		print_verdict();
	end
	initial begin
		#3000000;
		fails++;
		print_verdict();
	end
endmodule // testbench
